// File: hdl/tmr2_pkg.sv
`default_nettype none
package tmr2_pkg;
	// ************************************************************
	// Bus widths
	// ************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PRE_W  = 10;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS = 8'h37;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h70;
	localparam logic [ADDR_W-1:0] OFS_CTRL_A    = 8'hB0;
	localparam logic [ADDR_W-1:0] OFS_CTRL_B    = 8'hB1;
	localparam logic [ADDR_W-1:0] OFS_COUNTER   = 8'hB2;
	localparam logic [ADDR_W-1:0] OFS_CMP_A     = 8'hB3;
	localparam logic [ADDR_W-1:0] OFS_CMP_B     = 8'hB4;
	localparam logic [ADDR_W-1:0] OFS_ASYNC     = 8'hB6;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int FORCE_A_BIT  = 7;
	localparam int FORCE_B_BIT  = 6;
	localparam int WGM_HI_BIT   = 3;
	localparam int CS_MSB       = 2;
	localparam int OUTA_MSB     = 7;
	localparam int OUTA_LSB     = 6;
	localparam int OUTB_MSB     = 5;
	localparam int OUTB_LSB     = 4;
	localparam int WGM_LO_MSB   = 1;
	localparam int EXT_CLK_BIT  = 6;
	localparam int ASYNC_BIT    = 5;
	localparam int FLAG_B_BIT   = 2;
	localparam int FLAG_A_BIT   = 1;
	localparam int FLAG_OVF_BIT = 0;
	localparam int IRQ_W        = 3;

	// ************************************************************
	// Reset values and counter limits
	// ************************************************************
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam logic [DATA_W-1:0] BOTTOM    = 8'h00;
	localparam logic [DATA_W-1:0] MAX_VAL   = 8'hFF;

	// ************************************************************
	// Waveform mode low bits and compare output modes
	// ************************************************************
	localparam logic [1:0] WGM_NORMAL = 2'h0;
	localparam logic [1:0] WGM_PHASE  = 2'h1;
	localparam logic [1:0] WGM_CTC    = 2'h2;
	localparam logic [1:0] WGM_FAST   = 2'h3;
	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;

	// ************************************************************
	// Clock select codes and divider masks
	// ************************************************************
	localparam logic [2:0] CS_STOP  = 3'h0;
	localparam logic [2:0] CS_DIV1  = 3'h1;
	localparam logic [2:0] CS_DIV8  = 3'h2;
	localparam logic [2:0] CS_DIV32 = 3'h3;
	localparam logic [2:0] CS_DIV64 = 3'h4;
	localparam logic [2:0] CS_DIV128 = 3'h5;
	localparam logic [2:0] CS_DIV256 = 3'h6;
	localparam logic [2:0] CS_DIV1024 = 3'h7;
	localparam logic [PRE_W-1:0] MASK_DIV1    = 10'h000;
	localparam logic [PRE_W-1:0] MASK_DIV8    = 10'h007;
	localparam logic [PRE_W-1:0] MASK_DIV32   = 10'h01F;
	localparam logic [PRE_W-1:0] MASK_DIV64   = 10'h03F;
	localparam logic [PRE_W-1:0] MASK_DIV128  = 10'h07F;
	localparam logic [PRE_W-1:0] MASK_DIV256  = 10'h0FF;
	localparam logic [PRE_W-1:0] MASK_DIV1024 = 10'h3FF;
endpackage
`default_nettype wire

// File: hdl/tmr2_ctrl.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module tmr2_ctrl
	import tmr2_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [DATA_W-1:0] regRdData,
	input  wire logic              globalIrqEnable,
	input  wire logic [IRQ_W-1:0]  vectorAck,
	output logic      [IRQ_W-1:0]  irqReq,
	input  wire logic              osc_input_pin,
	output logic                   waveOutA,
	output logic                   waveOutB,
	output logic                   waveConnA,
	output logic                   waveConnB,
	output logic                   extClkBufEn,
	output logic                   oscRunEn
);

	// ************************************************************
	// State
	// ************************************************************
	// Every register of the block in one word
	// Controls, flags and prescaler all reset to zero
	// Prescaler runs on while stopped, so a new ratio
	// may give a short first period
	// pre is the free divider; rdData is the answer cycle
	typedef struct packed {
		logic [DATA_W-1:0] cnt;
		logic [DATA_W-1:0] cmpA;
		logic [DATA_W-1:0] cmpB;
		logic [1:0]        outModeA;
		logic [1:0]        outModeB;
		logic [1:0]        wgmLo;
		logic              wgmHi;
		logic [2:0]        clkSel;
		logic [IRQ_W-1:0]  irqMask;
		logic [IRQ_W-1:0]  flags;
		logic              extClk;
		logic              asyncSel;
		logic              countDown;
		logic              blockMatch;
		logic [PRE_W-1:0]  pre;
		logic              waveA;
		logic              waveB;
		logic [DATA_W-1:0] rdData;
		logic [2:0]        oscSync;
	} tmr2_state_t;

	tmr2_state_t state_r;
	tmr2_state_t state_nxt;

	// Non-PWM compare action on one pin
	// Off keeps the level; the connect output decides
	// whether it reaches the pad
	function automatic logic waveAction(input logic [1:0] mode, input logic cur);
		logic res;
		res = cur;
		unique case (mode)
			COM_TOGGLE: res = ~cur;
			COM_CLEAR:  res = 1'b0;
			COM_SET:    res = 1'b1;
			COM_OFF:    res = cur;
		endcase
		return res;
	endfunction

	// Divider mask for the selected ratio
	// Tick when all masked divider bits are ones
	// Stop shares the undivided mask; tick is gated off
	function automatic logic [PRE_W-1:0] divMask(input logic [2:0] sel);
		logic [PRE_W-1:0] m;
		m = MASK_DIV1;
		unique case (sel)
			CS_STOP, CS_DIV1: m = MASK_DIV1;
			CS_DIV8:          m = MASK_DIV8;
			CS_DIV32:         m = MASK_DIV32;
			CS_DIV64:         m = MASK_DIV64;
			CS_DIV128:        m = MASK_DIV128;
			CS_DIV256:        m = MASK_DIV256;
			CS_DIV1024:       m = MASK_DIV1024;
		endcase
		return m;
	endfunction

	// ************************************************************
	// Next-state logic
	// ************************************************************
	// Locals first, each given a value below,
	// so nothing is held over from the last pass
	always_comb begin
		logic             oscEdge;
		logic             srcTick;
		logic             tick;
		logic             isPwm;
		logic             isFast;
		logic             isPhase;
		logic [DATA_W-1:0] topVal;
		logic             atTop;
		logic             ovfEvt;
		logic             matchA;
		logic             matchB;
		logic             bottomEvt;
		logic [IRQ_W-1:0] flagSet;
		logic [IRQ_W-1:0] flagClr;
		oscEdge   = 1'b0;
		srcTick   = 1'b0;
		tick      = 1'b0;
		isPwm     = 1'b0;
		isFast    = 1'b0;
		isPhase   = 1'b0;
		topVal    = MAX_VAL;
		atTop     = 1'b0;
		ovfEvt    = 1'b0;
		matchA    = 1'b0;
		matchB    = 1'b0;
		bottomEvt = 1'b0;
		flagSet   = '0;
		flagClr   = '0;
		state_nxt = state_r;

		// Pin synchroniser; only stages 2 and 3 feed the edge detect
		// Third stage only remembers the old level
		// Pin edges must be slower than the core clock
		// by a wide margin, or edges are lost
		state_nxt.oscSync = {state_r.oscSync[1:0], osc_input_pin};
		oscEdge = state_r.oscSync[1] & ~state_r.oscSync[2];

		// Source clock: core clock or oscillator pin edges
		// Core clock source ticks every cycle
		// A pin edge counts about three core clocks late
		srcTick = state_r.asyncSel ? oscEdge : 1'b1;
		if (srcTick) begin
			state_nxt.pre = state_r.pre + 1'b1;
		end
		tick = srcTick && (state_r.clkSel != CS_STOP)
			&& ((state_r.pre & divMask(state_r.clkSel)) == divMask(state_r.clkSel));

		// Mode decode
		// PWM is any mode with the low bit set
		// Reserved modes with the high bit set decode by low bits,
		// with top still taken from compare A
		isPwm   = state_r.wgmLo[0];
		isFast  = (state_r.wgmLo == WGM_FAST);
		isPhase = (state_r.wgmLo == WGM_PHASE);
		topVal  = (state_r.wgmHi || state_r.wgmLo == WGM_CTC) ? state_r.cmpA : MAX_VAL;
		atTop   = (state_r.cnt == topVal);

		// Compare against current count, unless a counter write blocks it
		// Block lasts one timer tick, not one core clock,
		// so slow ratios still lose exactly one match
		matchA = tick && !state_r.blockMatch && (state_r.cnt == state_r.cmpA);
		matchB = tick && !state_r.blockMatch && (state_r.cnt == state_r.cmpB);
		if (tick) begin
			state_nxt.blockMatch = 1'b0;
		end

		// Counting sequence
		// A counter write wins: the write case below
		// overrides cnt after this block
		// Phase mode turns at top and at bottom;
		// overflow marks the turn at bottom
		if (tick) begin
			if (isPhase) begin
				if (!state_r.countDown) begin
					if (atTop) begin
						state_nxt.countDown = 1'b1;
						state_nxt.cnt       = state_r.cnt - 1'b1;
					end else begin
						state_nxt.cnt = state_r.cnt + 1'b1;
					end
				end else if (state_r.cnt == BOTTOM) begin
					state_nxt.countDown = 1'b0;
					state_nxt.cnt       = state_r.cnt + 1'b1;
					ovfEvt              = 1'b1;
				end else begin
					state_nxt.cnt = state_r.cnt - 1'b1;
				end
			end else if (isFast) begin
				state_nxt.countDown = 1'b0;
				state_nxt.cnt       = atTop ? BOTTOM : state_r.cnt + 1'b1;
				ovfEvt              = atTop;
				bottomEvt           = atTop;
			end else if (state_r.wgmLo == WGM_CTC) begin
				state_nxt.countDown = 1'b0;
				state_nxt.cnt       = atTop ? BOTTOM : state_r.cnt + 1'b1;
				ovfEvt              = (state_r.cnt == MAX_VAL);
			end else begin
				state_nxt.countDown = 1'b0;
				state_nxt.cnt       = state_r.cnt + 1'b1;
				ovfEvt              = (state_r.cnt == MAX_VAL);
			end
		end

		// Waveform units
		// Compare equal to top is not special-cased
		// Trade-off: fewer terms, edge duty cycles differ
		if (!isPwm) begin
			if (matchA) begin
				state_nxt.waveA = waveAction(state_r.outModeA, state_r.waveA);
			end
			if (matchB) begin
				state_nxt.waveB = waveAction(state_r.outModeB, state_r.waveB);
			end
		end else begin
			// Mode 2'b01 toggles only channel A, and only with top from compare A
			if (matchA) begin
				unique case (state_r.outModeA)
					COM_TOGGLE: state_nxt.waveA = state_r.wgmHi ? ~state_r.waveA : state_r.waveA;
					COM_CLEAR:  state_nxt.waveA = isFast ? 1'b0 : state_r.countDown;
					COM_SET:    state_nxt.waveA = isFast ? 1'b1 : ~state_r.countDown;
					COM_OFF:    state_nxt.waveA = state_r.waveA;
				endcase
			end
			if (matchB) begin
				unique case (state_r.outModeB)
					COM_CLEAR:        state_nxt.waveB = isFast ? 1'b0 : state_r.countDown;
					COM_SET:          state_nxt.waveB = isFast ? 1'b1 : ~state_r.countDown;
					COM_OFF, COM_TOGGLE: state_nxt.waveB = state_r.waveB;
				endcase
			end
			// Fast mode restores the level at bottom
			if (bottomEvt) begin
				if (state_r.outModeA[1]) begin
					state_nxt.waveA = ~state_r.outModeA[0];
				end
				if (state_r.outModeB[1]) begin
					state_nxt.waveB = ~state_r.outModeB[0];
				end
			end
		end

		// Event flags
		// Vector ack and a written one both clear;
		// merged below with the set terms
		flagSet[FLAG_OVF_BIT] = ovfEvt;
		flagSet[FLAG_A_BIT]   = matchA;
		flagSet[FLAG_B_BIT]   = matchB;
		flagClr = vectorAck;

		// ********************************************************
		// Register writes
		// ********************************************************
		// Unmapped addresses are ignored
		// Force bits act at the write edge and are not stored
		if (regWr) begin
			unique case (regAddr)
				OFS_IRQ_FLAGS: flagClr = flagClr | regWrData[IRQ_W-1:0];
				OFS_IRQ_MASK:  state_nxt.irqMask = regWrData[IRQ_W-1:0];
				OFS_CTRL_A: begin
					state_nxt.outModeA = regWrData[OUTA_MSB:OUTA_LSB];
					state_nxt.outModeB = regWrData[OUTB_MSB:OUTB_LSB];
					state_nxt.wgmLo    = regWrData[WGM_LO_MSB:0];
				end
				OFS_CTRL_B: begin
					state_nxt.wgmHi  = regWrData[WGM_HI_BIT];
					state_nxt.clkSel = regWrData[CS_MSB:0];
					// Forced match: pin only, no flag, no counter clear
					if (!isPwm && regWrData[FORCE_A_BIT]) begin
						state_nxt.waveA = waveAction(state_r.outModeA, state_r.waveA);
					end
					if (!isPwm && regWrData[FORCE_B_BIT]) begin
						state_nxt.waveB = waveAction(state_r.outModeB, state_r.waveB);
					end
				end
				OFS_COUNTER: begin
					state_nxt.cnt        = regWrData;
					state_nxt.blockMatch = 1'b1;
				end
				OFS_CMP_A: state_nxt.cmpA = regWrData;
				OFS_CMP_B: state_nxt.cmpB = regWrData;
				OFS_ASYNC: begin
					state_nxt.extClk   = regWrData[EXT_CLK_BIT];
					state_nxt.asyncSel = regWrData[ASYNC_BIT];
				end
				default: begin
				end
			endcase
		end

		// A new event wins over a clear in the same cycle
		// so a match is never lost to a late clear
		state_nxt.flags = (state_r.flags & ~flagClr) | flagSet;

		// ********************************************************
		// Register reads, answered one cycle later
		// ********************************************************
		// Zero outside the answer cycle, so the read
		// data of several slaves may be ORed
		state_nxt.rdData = REG_RESET;
		if (regRd) begin
			unique case (regAddr)
				OFS_IRQ_FLAGS: state_nxt.rdData[IRQ_W-1:0] = state_r.flags;
				OFS_IRQ_MASK:  state_nxt.rdData[IRQ_W-1:0] = state_r.irqMask;
				OFS_CTRL_A: begin
					state_nxt.rdData[OUTA_MSB:OUTA_LSB] = state_r.outModeA;
					state_nxt.rdData[OUTB_MSB:OUTB_LSB] = state_r.outModeB;
					state_nxt.rdData[WGM_LO_MSB:0]      = state_r.wgmLo;
				end
				OFS_CTRL_B: begin
					// Force strobes and reserved bits stay zero
					state_nxt.rdData[WGM_HI_BIT] = state_r.wgmHi;
					state_nxt.rdData[CS_MSB:0]   = state_r.clkSel;
				end
				OFS_COUNTER: state_nxt.rdData = state_r.cnt;
				OFS_CMP_A:   state_nxt.rdData = state_r.cmpA;
				OFS_CMP_B:   state_nxt.rdData = state_r.cmpB;
				OFS_ASYNC: begin
					state_nxt.rdData[EXT_CLK_BIT] = state_r.extClk;
					state_nxt.rdData[ASYNC_BIT]   = state_r.asyncSel;
				end
				default: state_nxt.rdData = REG_RESET;
			endcase
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Async reset loads constants only
	// and holds every output at its idle level
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign regRdData   = state_r.rdData;
	// Requests follow flags at once; global enable gates all three
	assign irqReq      = state_r.irqMask & state_r.flags & {IRQ_W{globalIrqEnable}};
	assign waveOutA    = state_r.waveA;
	assign waveOutB    = state_r.waveB;
	// Pin connected whenever out mode is not off,
	// in every waveform mode
	assign waveConnA   = (state_r.outModeA != COM_OFF);
	assign waveConnB   = (state_r.outModeB != COM_OFF);
	// Buffer only matters when the pin is the timer source
	assign extClkBufEn = state_r.extClk & state_r.asyncSel;
	assign oscRunEn    = ~state_r.extClk;

endmodule // tmr2_ctrl
`default_nettype wire

// File: tb/tmr2_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module tmr2_ctrl_sva
	import tmr2_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              rstn,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic              regWr,
	input wire logic              regRd,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic              globalIrqEnable,
	input wire logic [IRQ_W-1:0]  irqReq,
	input wire logic              waveOutA,
	input wire logic              waveConnA,
	input wire logic              extClkBufEn,
	input wire logic              oscRunEn
);
	logic [DATA_W-1:0] ctlA_r;
	logic [IRQ_W-1:0]  mask_r;
	logic              pwmMode;

	// Shadow copies of control A and mask, so checks need no internal peeking
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctlA_r <= 8'h00;
			mask_r <= 3'h0;
		end else if (regWr && regAddr == OFS_CTRL_A) begin
			ctlA_r <= regWrData;
		end else if (regWr && regAddr == OFS_IRQ_MASK) begin
			mask_r <= regWrData[IRQ_W-1:0];
		end
	end
	// Both PWM codes have the low bit set
	assign pwmMode = ctlA_r[0];

	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_force_a;
		regWr && regAddr == OFS_CTRL_B && regWrData[FORCE_A_BIT];
	endsequence
	sequence s_force_live;
		!pwmMode && ctlA_r[OUTA_MSB];
	endsequence
	property p_force_a;
		s_force_a ##0 s_force_live |=> waveOutA == $past(ctlA_r[OUTA_LSB]);
	endproperty
	property p_irq_gate;
		irqReq != 3'h0 |-> globalIrqEnable && (irqReq & ~mask_r) == 3'h0;
	endproperty
	property p_rd_ctlb;
		regRd && regAddr == OFS_CTRL_B |=> regRdData[7:4] == 4'h0;
	endproperty
	property p_rd_async;
		regRd && regAddr == OFS_ASYNC |=> !regRdData[7];
	endproperty
	property p_ext_buf;
		extClkBufEn |-> !oscRunEn;
	endproperty
	property p_osc_run;
		$changed(oscRunEn) |-> $past(regWr) && $past(regAddr) == OFS_ASYNC
			&& oscRunEn == !$past(regWrData[EXT_CLK_BIT]);
	endproperty
	property p_buf_rise;
		$rose(extClkBufEn) |-> $past(regWr) && $past(regAddr) == OFS_ASYNC && $past(regWrData[ASYNC_BIT]);
	endproperty
	property p_conn_a;
		$changed(waveConnA) |-> $past(regWr) && $past(regAddr) == OFS_CTRL_A
			&& waveConnA == (ctlA_r[OUTA_MSB:OUTA_LSB] != 2'h0);
	endproperty
	a_force_a: assert property (p_force_a) else $error("forced level on A wrong");
	a_irq_gate: assert property (p_irq_gate) else $error("request without enable");
	a_rd_ctlb: assert property (p_rd_ctlb) else $error("control B high nibble not zero");
	a_rd_async: assert property (p_rd_async) else $error("async bit 7 not zero");
	a_ext_buf: assert property (p_ext_buf) else $error("buffer on with crystal running");
	a_osc_run: assert property (p_osc_run) else $error("crystal enable changed wrongly");
	a_buf_rise: assert property (p_buf_rise) else $error("buffer rose without async write");
	a_conn_a: assert property (p_conn_a) else $error("pin connect A changed wrongly");
endmodule // tmr2_ctrl_sva
`default_nettype wire

// File: tb/tmr2_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tmr2_ctrl_tb
	import tmr2_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} tmr2_row_t;
	// Address, written value, read-back value
	localparam tmr2_row_t ROWS [13] = '{'{8'h70, 8'hFF, 8'h07}, '{8'hB3, 8'hA5, 8'hA5}, '{8'hB4, 8'h5A, 8'h5A},
		'{8'hB1, 8'hF8, 8'h08}, '{8'hB1, 8'h00, 8'h00}, '{8'hB2, 8'hC3, 8'hC3}, '{8'hB0, 8'hFF, 8'hF3},
		'{8'hB0, 8'h00, 8'h00}, '{8'hB6, 8'h40, 8'h40}, '{8'hB6, 8'hFF, 8'h60}, '{8'hB6, 8'h00, 8'h00},
		'{8'h37, 8'hFF, 8'h00}, '{8'h55, 8'hFF, 8'h00}};
	localparam int DIVS [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
	logic              core_clk = 1'b0;
	logic              rstn = 1'b0;
	logic [ADDR_W-1:0] regAddr = 8'h00;
	logic [DATA_W-1:0] regWrData = 8'h00;
	logic              regWr = 1'b0;
	logic              regRd = 1'b0;
	logic              globalIrqEnable = 1'b1;
	logic [IRQ_W-1:0]  vectorAck = 3'h0;
	logic              osc_input_pin = 1'b0;
	logic [DATA_W-1:0] regRdData;
	logic [IRQ_W-1:0]  irqReq;
	logic              waveOutA, waveOutB, waveConnA, waveConnB, extClkBufEn, oscRunEn;
	int                errors = 0;
	int                n_compared = 0;
	int                cycles = 0;

	tmr2_ctrl u_dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .globalIrqEnable(globalIrqEnable),
		.vectorAck(vectorAck), .irqReq(irqReq), .osc_input_pin(osc_input_pin), .waveOutA(waveOutA),
		.waveOutB(waveOutB), .waveConnA(waveConnA), .waveConnB(waveConnB), .extClkBufEn(extClkBufEn),
		.oscRunEn(oscRunEn));

	// ************************************************************
	// Bus tasks and checks
	// ************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Strobe for one cycle, then settle at the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
		@(negedge core_clk);
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(negedge core_clk);
		d = regRdData;
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Clock and hang guard; the divide-by-1024 pass dominates run time
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			final_report();
		end
	end

	// Main sequence
	initial begin
		logic [7:0] v;
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		chk({irqReq, waveOutA, waveOutB, waveConnA, waveConnB, oscRunEn}, 8'h01);
		foreach (ROWS[i]) begin
			rd(ROWS[i].a, v);
			chk(v, 8'h00);
		end
		$display("reset values done");
		foreach (ROWS[i]) begin
			wr(ROWS[i].a, ROWS[i].d);
			rd(ROWS[i].a, v);
			chk(v, ROWS[i].e);
			if (ROWS[i].a == OFS_ASYNC) begin
				chk({6'h00, extClkBufEn, oscRunEn},
					{6'h00, ROWS[i].d[EXT_CLK_BIT] & ROWS[i].d[ASYNC_BIT], !ROWS[i].d[EXT_CLK_BIT]});
			end
		end
		$display("register rows done");
		for (int cs = 0; cs < 8; cs++) begin
			wr(OFS_COUNTER, 8'h00);
			wr(OFS_CTRL_B, 8'(cs));
			repeat (cs == 0 ? 16 : 4 * DIVS[cs] - 2) @(posedge core_clk);
			wr(OFS_CTRL_B, 8'h00);
			rd(OFS_COUNTER, v);
			chk(v, cs == 0 ? 8'h00 : 8'h04);
		end
		$display("clock select done");
		wr(OFS_CMP_A, 8'h05);
		wr(OFS_CMP_B, 8'h06);
		wr(OFS_COUNTER, 8'h03);
		wr(OFS_IRQ_MASK, 8'h07);
		wr(OFS_CTRL_B, {5'h00, CS_DIV1});
		repeat (6) @(posedge core_clk);
		wr(OFS_CTRL_B, 8'h00);
		chk({5'h00, irqReq}, 8'h06);
		rd(OFS_IRQ_FLAGS, v);
		chk(v, 8'h06);
		@(posedge core_clk);
		globalIrqEnable <= 1'b0;
		@(negedge core_clk);
		chk({5'h00, irqReq}, 8'h00);
		@(posedge core_clk);
		globalIrqEnable <= 1'b1;
		wr(OFS_IRQ_MASK, 8'h02);
		chk({5'h00, irqReq}, 8'h02);
		wr(OFS_IRQ_FLAGS, 8'h02);
		rd(OFS_IRQ_FLAGS, v);
		chk(v, 8'h04);
		@(posedge core_clk);
		vectorAck <= 3'h4;
		@(posedge core_clk);
		vectorAck <= 3'h0;
		rd(OFS_IRQ_FLAGS, v);
		chk(v, 8'h00);
		// Counter lands on compare A while stopped, so the first tick is blocked
		wr(OFS_COUNTER, 8'h05);
		wr(OFS_CTRL_B, {5'h00, CS_DIV1});
		repeat (6) @(posedge core_clk);
		wr(OFS_CTRL_B, 8'h00);
		rd(OFS_IRQ_FLAGS, v);
		chk(v, 8'h04);
		wr(OFS_IRQ_FLAGS, 8'h07);
		wr(OFS_COUNTER, 8'hFD);
		wr(OFS_CTRL_B, {5'h00, CS_DIV1});
		repeat (4) @(posedge core_clk);
		wr(OFS_CTRL_B, 8'h00);
		rd(OFS_IRQ_FLAGS, v);
		chk(v, 8'h01);
		$display("flags and requests done");
		// Timer stopped: only forced strobes can move the pins
		wr(OFS_IRQ_FLAGS, 8'h07);
		wr(OFS_CTRL_A, 8'hD0);
		wr(OFS_CTRL_B, 8'hC0);
		chk({4'h0, waveConnA, waveConnB, waveOutA, waveOutB}, 8'h0F);
		wr(OFS_COUNTER, 8'h05);
		wr(OFS_CTRL_A, 8'h92);
		wr(OFS_CTRL_B, 8'hC0);
		chk({4'h0, waveConnA, waveConnB, waveOutA, waveOutB}, 8'h0C);
		rd(OFS_COUNTER, v);
		chk(v, 8'h05);
		rd(OFS_IRQ_FLAGS, v);
		chk(v, 8'h00);
		rd(OFS_CTRL_B, v);
		chk(v, 8'h00);
		wr(OFS_CTRL_A, 8'hD3);
		wr(OFS_CTRL_B, 8'hC0);
		chk({6'h00, waveOutA, waveConnA}, 8'h01);
		wr(OFS_CTRL_B, 8'h00);
		chk({6'h00, waveOutA, waveConnA}, 8'h01);
		$display("forced compare done");
		// Phase PWM, top from compare A: 3 up to 5, down to 0, turn, up to 2
		wr(OFS_IRQ_FLAGS, 8'h07);
		wr(OFS_CTRL_A, 8'h01);
		wr(OFS_CMP_A, 8'h05);
		wr(OFS_COUNTER, 8'h03);
		wr(OFS_CTRL_B, 8'h09);
		repeat (7) @(posedge core_clk);
		wr(OFS_CTRL_B, 8'h00);
		rd(OFS_COUNTER, v);
		chk(v, 8'h02);
		rd(OFS_IRQ_FLAGS, v);
		chk(v, 8'h03);
		$display("phase PWM done");
		// Pin as timer source: five rising edges give five counts
		wr(OFS_CTRL_A, 8'h00);
		wr(OFS_ASYNC, 8'h40);
		wr(OFS_ASYNC, 8'h60);
		wr(OFS_COUNTER, 8'h00);
		wr(OFS_CTRL_B, {5'h00, CS_DIV1});
		repeat (10) begin
			repeat (2) @(posedge core_clk);
			osc_input_pin <= !osc_input_pin;
		end
		wr(OFS_CTRL_B, 8'h00);
		rd(OFS_COUNTER, v);
		chk(v, 8'h05);
		wr(OFS_ASYNC, 8'h00);
		$display("pin clock done");
		// Reset in mid-run with live settings and flags
		wr(OFS_CTRL_A, 8'hD0);
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		chk({irqReq, waveOutA, waveOutB, waveConnA, waveConnB, oscRunEn}, 8'h01);
		rd(OFS_CTRL_A, v);
		chk(v, 8'h00);
		rd(OFS_IRQ_FLAGS, v);
		chk(v, 8'h00);
		$display("mid-run reset done");
		final_report();
	end
endmodule // tmr2_ctrl_tb

bind tmr2_ctrl tmr2_ctrl_sva u_sva (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
	.globalIrqEnable(globalIrqEnable), .irqReq(irqReq), .waveOutA(waveOutA), .waveConnA(waveConnA),
	.extClkBufEn(extClkBufEn), .oscRunEn(oscRunEn));
`default_nettype wire
